// ===== src/position_command_pulse_decoder.sv
`include "poscmd_params.svh"

module position_command_pulse_decoder import poscmd_pkg::*; #(
	parameter int POS_W = 32
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Command pulse pins
	input wire logic commandPulseInputA,
	input wire logic commandPulseInputB,
	// Drive pins
	input wire logic servoEnable,
	input wire logic runForward,
	input wire logic runReverse,
	input wire logic photoSwitch,
	// Drive state from the control core
	input wire logic closedLoopVectorMode,
	input wire logic spindleOrient,
	input wire logic orientMoving,
	input wire logic [15:0] torqueCommand,
	input wire logic [15:0] speedCommand,
	// Results
	output logic [POS_W-1:0] positionCount,
	output logic positionControl,
	output logic servoActive,
	output logic [3:0] commandSource,
	output logic stopStart,
	output logic [15:0] stopDistance,
	output logic [15:0] loopGain,
	output logic movingAvgFilter,
	output logic overspeedEnable
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	localparam int TICK_CYC = `SMOOTH_TICK_CYC;
	localparam int TICK_W = $clog2(TICK_CYC + 1);

	if (POS_W < 16 || POS_W > 32) begin : g_chk
		$error("POS_W must be 16 to 32");
	end

	typedef struct packed {
		logic [15:0] cfg;
		logic [15:0] fmt;
		logic [15:0] gain1;
		logic [15:0] gain2;
		logic [15:0] swMode;
		logic [15:0] tqLvl;
		logic [15:0] spLvl;
		logic [15:0] smooth;
		logic [15:0] digPos;
		logic [POS_W-1:0] pos;
		logic [19:0] gainAcc;
		logic [TICK_W-1:0] tick;
		logic [1:0] senSync;
		logic [1:0] fwdSync;
		logic [1:0] revSync;
		logic [1:0] photoSync;
		logic photoPrev;
		logic servo;
		logic ctrlPos;
		logic stop;
		logic ack;
		logic [31:0] rdat;
	} main_state_t;

	main_state_t s_r;
	main_state_t s_nxt;
	pulse_if pulses();

	logic [3:0] source;
	logic [15:0] target;
	logic tickNow;
	logic dirReverse;
	logic busReq;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [31:0] dat, input logic [3:0] sel);
		logic [15:0] res;
		res = old;
		if (sel[0]) begin
			res[7:0] = dat[7:0];
		end
		if (sel[1]) begin
			res[15:8] = dat[15:8];
		end
		return res;
	endfunction

	function automatic logic [19:0] smoothStep(input logic [19:0] acc,
		input logic [15:0] tgt, input logic [3:0] coef);
		logic signed [20:0] diff;
		logic signed [20:0] step;
		diff = $signed({1'b0, tgt, 4'h0}) - $signed({1'b0, acc});
		step = diff >>> coef;
		// Keep the last fraction moving so the target is always reached
		if (step == 21'sd0 && diff != 21'sd0) begin
			step = (diff < 0) ? -21'sd1 : 21'sd1;
		end
		return 20'($signed({1'b0, acc}) + step);
	endfunction

	// ------------------------------------------------------------
	// Pulse decoding
	// ------------------------------------------------------------
	pulse_decoder u_decoder (
		.clock(clock),
		.rst_n(rst_n),
		.pulseA(commandPulseInputA),
		.pulseB(commandPulseInputB),
		.pulses(pulses.decoder)
	);

	assign pulses.format = pulse_fmt_t'(s_r.fmt[`FMT_MODE_LSB +: 2]);

	// ------------------------------------------------------------
	// Combinational terms
	// ------------------------------------------------------------
	assign source = s_r.cfg[`CFG_SRC_LSB +: 4];
	assign tickNow = (s_r.tick == TICK_W'(TICK_CYC - 1));
	assign busReq = wb_cyc_i & wb_stb_i & ~s_r.ack;
	// Reverse is the synchronised reverse run command when the run bit is set, else the direction bit
	assign dirReverse = s_r.fmt[`FMT_DIR_RUN_BIT] ? s_r.revSync[1]
		: s_r.fmt[`FMT_DIR_BIT];

	always_comb begin
		target = s_r.gain1;
		if (spindleOrient) begin
			target = orientMoving ? s_r.gain2 : s_r.gain1;
		end else begin
			case (gain_sw_t'(s_r.swMode[1:0]))
				GSW_NONE: begin
					target = s_r.gain1;
				end
				GSW_TORQUE: begin
					if (s_r.swMode[15:2] == 14'h0000
						&& torqueCommand >= s_r.tqLvl) begin
						target = s_r.gain2;
					end
				end
				GSW_SPEED: begin
					if (s_r.swMode[15:2] == 14'h0000
						&& speedCommand >= s_r.spLvl) begin
						target = s_r.gain2;
					end
				end
				default: begin
					target = s_r.gain1;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.senSync = {s_r.senSync[0], servoEnable};
		s_nxt.fwdSync = {s_r.fwdSync[0], runForward};
		s_nxt.revSync = {s_r.revSync[0], runReverse};
		s_nxt.photoSync = {s_r.photoSync[0], photoSwitch};
		s_nxt.photoPrev = s_r.photoSync[1];

		s_nxt.ctrlPos = closedLoopVectorMode & s_r.cfg[`CFG_CTRL_BIT];
		// Without servo enable only a run command brings servo up
		s_nxt.servo = s_r.ctrlPos
			& (source == `SRC_PULSE || spindleOrient)
			& (s_r.senSync[1] | s_r.fwdSync[1] | s_r.revSync[1]);
		s_nxt.stop = (source == `SRC_PHOTO)
			& s_r.photoSync[1] & ~s_r.photoPrev;

		if (pulses.countUp != pulses.countDown) begin
			if (pulses.countUp ^ dirReverse) begin
				s_nxt.pos = s_r.pos + POS_W'(1);
			end else begin
				s_nxt.pos = s_r.pos - POS_W'(1);
			end
		end

		s_nxt.tick = tickNow ? '0 : s_r.tick + TICK_W'(1);
		if (s_r.smooth[3:0] == 4'h0) begin
			s_nxt.gainAcc = {target, 4'h0};
		end else if (tickNow) begin
			s_nxt.gainAcc = smoothStep(s_r.gainAcc, target,
				s_r.smooth[3:0]);
		end

		// Answer every access one cycle later, unmapped reads return zero
		s_nxt.ack = busReq;
		if (busReq && !wb_we_i) begin
			case (wb_adr_i)
				`OFS_POS_CFG: s_nxt.rdat = {16'h0000, s_r.cfg};
				`OFS_FORMAT: s_nxt.rdat = {16'h0000, s_r.fmt};
				`OFS_GAIN1: s_nxt.rdat = {16'h0000, s_r.gain1};
				`OFS_GAIN2: s_nxt.rdat = {16'h0000, s_r.gain2};
				`OFS_SW_MODE: s_nxt.rdat = {16'h0000, s_r.swMode};
				`OFS_TQ_LVL: s_nxt.rdat = {16'h0000, s_r.tqLvl};
				`OFS_SP_LVL: s_nxt.rdat = {16'h0000, s_r.spLvl};
				`OFS_SMOOTH: s_nxt.rdat = {16'h0000, s_r.smooth};
				`OFS_DIG_POS: s_nxt.rdat = {16'h0000, s_r.digPos};
				`OFS_POS_CNT: s_nxt.rdat = 32'(s_r.pos);
				`OFS_STATUS: s_nxt.rdat = {29'h0000_0000,
					target == s_r.gain2, s_r.ctrlPos, s_r.servo};
				default: s_nxt.rdat = 32'h0000_0000;
			endcase
		end
		if (busReq && wb_we_i) begin
			case (wb_adr_i)
				`OFS_POS_CFG: s_nxt.cfg = wr16(s_r.cfg, wb_dat_i, wb_sel_i);
				`OFS_FORMAT: s_nxt.fmt = wr16(s_r.fmt, wb_dat_i, wb_sel_i);
				`OFS_GAIN1: s_nxt.gain1 = wr16(s_r.gain1, wb_dat_i, wb_sel_i);
				`OFS_GAIN2: s_nxt.gain2 = wr16(s_r.gain2, wb_dat_i, wb_sel_i);
				`OFS_SW_MODE: s_nxt.swMode = wr16(s_r.swMode, wb_dat_i,
					wb_sel_i);
				`OFS_TQ_LVL: s_nxt.tqLvl = wr16(s_r.tqLvl, wb_dat_i, wb_sel_i);
				`OFS_SP_LVL: s_nxt.spLvl = wr16(s_r.spLvl, wb_dat_i, wb_sel_i);
				`OFS_SMOOTH: s_nxt.smooth = wr16(s_r.smooth, wb_dat_i,
					wb_sel_i);
				`OFS_DIG_POS: s_nxt.digPos = wr16(s_r.digPos, wb_dat_i,
					wb_sel_i);
				default: s_nxt.rdat = s_r.rdat;
			endcase
		end

		if (!rst_n) begin
			s_nxt = '0;
			s_nxt.cfg = `RST_POS_CFG;
			s_nxt.fmt = `RST_FORMAT;
			s_nxt.gain1 = `RST_GAIN1;
			s_nxt.gain2 = `RST_GAIN2;
			s_nxt.swMode = `RST_SW_MODE;
			s_nxt.tqLvl = `RST_TQ_LVL;
			s_nxt.spLvl = `RST_SP_LVL;
			s_nxt.smooth = `RST_SMOOTH;
			s_nxt.digPos = `RST_DIG_POS;
			s_nxt.gainAcc = {`RST_GAIN1, 4'h0};
		end
	end

	always_ff @(posedge clock) begin
		s_r <= s_nxt;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.rdat;
	assign positionCount = s_r.pos;
	assign positionControl = s_r.ctrlPos;
	assign servoActive = s_r.servo;
	assign commandSource = source;
	assign stopStart = s_r.stop;
	assign stopDistance = s_r.digPos;
	assign loopGain = s_r.gainAcc[19:4];
	assign movingAvgFilter = s_r.fmt[`FMT_FILTER_BIT];
	assign overspeedEnable = s_r.fmt[`FMT_OVERSPEED_BIT];

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	AST_CTRL_MODE: assert property (@(posedge clock)
		disable iff (!rst_n)
		!closedLoopVectorMode ##1 1'b1 |-> !positionControl)
		else $error("position control outside vector mode");

	AST_SERVO_CAUSE: assert property (@(posedge clock)
		disable iff (!rst_n)
		$rose(servoActive) |-> $past(s_r.senSync[1] | s_r.fwdSync[1]
			| s_r.revSync[1]) && $past(positionControl))
		else $error("servo started without enable or run");

	AST_PHOTO_STOP: assert property (@(posedge clock)
		disable iff (!rst_n)
		(source == `SRC_PHOTO && s_r.photoSync[1] && !s_r.photoPrev
			&& $stable(s_r.cfg)) |=> stopStart)
		else $error("photo switch did not start stop");

	AST_STOP_SRC: assert property (@(posedge clock)
		disable iff (!rst_n)
		stopStart |-> $past(source) == `SRC_PHOTO)
		else $error("stop started from wrong source");

	AST_DIR_REV: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.countUp && !pulses.countDown
			&& !s_r.fmt[`FMT_DIR_RUN_BIT] && s_r.fmt[`FMT_DIR_BIT])
		|=> positionCount == $past(positionCount) - POS_W'(1))
		else $error("reverse direction not applied");

	AST_ORIENT_GAIN: assert property (@(posedge clock)
		disable iff (!rst_n)
		spindleOrient && orientMoving |-> target == s_r.gain2)
		else $error("orientation did not pick second gain");

	AST_RSVD_GAIN: assert property (@(posedge clock)
		disable iff (!rst_n)
		!spindleOrient && s_r.swMode[1:0] == 2'b11 |-> target == s_r.gain1)
		else $error("reserved mode switched gain");

	AST_GAIN_NOW: assert property (@(posedge clock)
		disable iff (!rst_n)
		s_r.smooth[3:0] == 4'h0 |=> loopGain == $past(target))
		else $error("zero smoothing did not jump");

	AST_GAIN_HOLD: assert property (@(posedge clock)
		disable iff (!rst_n)
		s_r.smooth[3:0] != 4'h0 && !tickNow && $stable(s_r.smooth)
		|=> $stable(loopGain))
		else $error("gain moved between smoothing ticks");

endmodule

// ===== src/poscmd_params.svh
`ifndef POSCMD_PARAMS_SVH
`define POSCMD_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_POS_CFG 8'h00
`define OFS_FORMAT 8'h04
`define OFS_GAIN1 8'h08
`define OFS_GAIN2 8'h0C
`define OFS_SW_MODE 8'h10
`define OFS_TQ_LVL 8'h14
`define OFS_SP_LVL 8'h18
`define OFS_SMOOTH 8'h1C
`define OFS_DIG_POS 8'h20
`define OFS_POS_CNT 8'h24
`define OFS_STATUS 8'h28

// ------------------------------------------------------------
// Reset values (gains and levels in tenths)
// ------------------------------------------------------------
`define RST_POS_CFG 16'h0000
`define RST_FORMAT 16'h0000
`define RST_GAIN1 16'h00C8
`define RST_GAIN2 16'h012C
`define RST_SW_MODE 16'h0000
`define RST_TQ_LVL 16'h0064
`define RST_SP_LVL 16'h0064
`define RST_SMOOTH 16'h0005
`define RST_DIG_POS 16'h0000

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CFG_CTRL_BIT 0
`define CFG_SRC_LSB 4
`define FMT_MODE_LSB 0
`define FMT_DIR_BIT 4
`define FMT_DIR_RUN_BIT 5
`define FMT_FILTER_BIT 12
`define FMT_OVERSPEED_BIT 13

// ------------------------------------------------------------
// Command source codes
// ------------------------------------------------------------
`define SRC_PULSE 4'h0
`define SRC_DIGITAL 4'h1
`define SRC_PHOTO 4'h2

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define CLOCK_PERIOD_NS 20
`define SMOOTH_TICK_NS 1000
`define SMOOTH_TICK_CYC (`SMOOTH_TICK_NS / `CLOCK_PERIOD_NS)

`endif

// ===== src/poscmd_pkg.sv
package poscmd_pkg;

	typedef enum logic [1:0] {
		FMT_QUADRATURE,
		FMT_PULSE_SIGN,
		FMT_PULSE_ONLY,
		FMT_DUAL_CHANNEL
	} pulse_fmt_t;

	typedef enum logic [1:0] {
		GSW_NONE,
		GSW_TORQUE,
		GSW_SPEED,
		GSW_RESERVED
	} gain_sw_t;

endpackage

// ===== src/pulse_if.sv
interface pulse_if;
	import poscmd_pkg::*;
	pulse_fmt_t format;
	logic countUp;
	logic countDown;

	modport decoder (input format, output countUp, output countDown);
	modport user (output format, input countUp, input countDown);
endinterface

// ===== src/pulse_decoder.sv
module pulse_decoder import poscmd_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Command pulse pins
	input wire logic pulseA,
	input wire logic pulseB,
	// Decoded counts
	pulse_if.decoder pulses
);

	typedef struct packed {
		logic a1;
		logic a2;
		logic aPrev;
		logic b1;
		logic b2;
		logic bPrev;
		logic up;
		logic down;
	} dec_state_t;

	dec_state_t s_r;
	dec_state_t s_nxt;
	logic aRise;
	logic bRise;
	logic aChg;
	logic bChg;

	assign aRise = s_r.a2 & ~s_r.aPrev;
	assign bRise = s_r.b2 & ~s_r.bPrev;
	assign aChg = s_r.a2 ^ s_r.aPrev;
	assign bChg = s_r.b2 ^ s_r.bPrev;

	always_comb begin
		s_nxt = s_r;
		s_nxt.a1 = pulseA;
		s_nxt.a2 = s_r.a1;
		s_nxt.aPrev = s_r.a2;
		s_nxt.b1 = pulseB;
		s_nxt.b2 = s_r.b1;
		s_nxt.bPrev = s_r.b2;
		s_nxt.up = 1'b0;
		s_nxt.down = 1'b0;
		case (pulses.format)
			FMT_QUADRATURE: begin
				// A leading B is forward; a double step has no known sense
				if (aChg ^ bChg) begin
					s_nxt.up = s_r.a2 ^ s_r.bPrev;
					s_nxt.down = ~(s_r.a2 ^ s_r.bPrev);
				end
			end
			FMT_PULSE_SIGN: begin
				s_nxt.up = aRise & ~s_r.b2;
				s_nxt.down = aRise & s_r.b2;
			end
			FMT_PULSE_ONLY: begin
				s_nxt.up = aRise;
			end
			FMT_DUAL_CHANNEL: begin
				// Coincident edges cancel
				s_nxt.up = aRise & ~bRise;
				s_nxt.down = bRise & ~aRise;
			end
			default: begin
				s_nxt.up = 1'b0;
			end
		endcase
		if (!rst_n) begin
			s_nxt = '0;
		end
	end

	always_ff @(posedge clock) begin
		s_r <= s_nxt;
	end

	assign pulses.countUp = s_r.up;
	assign pulses.countDown = s_r.down;

	AST_SIGN_DIR: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.format == FMT_PULSE_SIGN && aRise)
		|=> (pulses.countUp == !$past(s_r.b2)) && (pulses.countDown == $past(s_r.b2)))
		else $error("pulse/sign decode wrong");

	AST_PULSE_ONLY: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.format == FMT_PULSE_ONLY) && $stable(pulses.format)
		|=> !pulses.countDown)
		else $error("pulse-only format counted down");

	AST_DUAL_B: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.format == FMT_DUAL_CHANNEL && bRise && !aRise)
		|=> pulses.countDown && !pulses.countUp)
		else $error("dual channel B edge not counted down");

	AST_QUAD_BOTH: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.format == FMT_QUADRATURE && aChg && bChg)
		|=> !pulses.countUp && !pulses.countDown)
		else $error("invalid quadrature step counted");

	AST_QUAD_FWD: assert property (@(posedge clock)
		disable iff (!rst_n)
		(pulses.format == FMT_QUADRATURE && aRise && !s_r.b2 && !bChg)
		|=> pulses.countUp)
		else $error("A leading B not counted forward");

endmodule

// ===== sim/pulse_source.sv
module pulse_source import poscmd_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Step request
	input wire logic go,
	input wire logic up,
	input wire logic skip,
	input wire pulse_fmt_t fmt,
	// Command pins
	output logic pinA,
	output logic pinB
);
	logic [1:0] quad_r;
	logic [3:0] cnt_r;
	logic up_r;
	logic noise_r;
	logic pulse;

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			quad_r <= 2'h0;
			cnt_r <= 4'h0;
			up_r <= 1'h1;
			noise_r <= 1'h0;
		end else begin
			noise_r <= ~noise_r;
			if (go) begin
				up_r <= up;
				// A skip moves both quadrature phases at once, no pulse
				cnt_r <= skip ? 4'h0 : 4'h8;
				quad_r <= skip ? quad_r + 2'h2
					: (up ? quad_r + 2'h1 : quad_r - 2'h1);
			end else if (cnt_r != 4'h0) begin
				cnt_r <= cnt_r - 4'h1;
			end
		end
	end

	// Sign settles four cycles before the pulse rises
	assign pulse = (cnt_r >= 4'h1) && (cnt_r <= 4'h4);

	always_comb begin
		case (fmt)
			FMT_QUADRATURE: begin
				pinA = quad_r[0] ^ quad_r[1];
				pinB = quad_r[1];
			end
			FMT_PULSE_SIGN: begin
				pinA = pulse;
				pinB = ~up_r;
			end
			FMT_PULSE_ONLY: begin
				pinA = pulse;
				// Unwired line: toggles so a stale level cannot hide
				pinB = noise_r;
			end
			default: begin
				pinA = pulse & up_r;
				pinB = pulse & ~up_r;
			end
		endcase
	end
endmodule

// ===== sim/position_command_pulse_decoder_tb.sv
module position_command_pulse_decoder_tb import poscmd_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [15:0] G1 = 16'h00C8;
	localparam logic [15:0] G2 = 16'h012C;
	logic clock = 1'h0;
	logic rst_n = 1'h0;
	logic cyc = 1'h0, stb = 1'h0, we = 1'h0, go = 1'h0, up = 1'h0;
	logic skip = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] datI = 32'h0000_0000;
	logic [31:0] rdat, wbDat, positionCount;
	logic servoEnable = 1'h0, runForward = 1'h0, runReverse = 1'h0;
	logic photoSwitch = 1'h0, vecMode = 1'h0;
	logic spindleOrient = 1'h0, orientMoving = 1'h0;
	logic [15:0] torqueCmd = 16'h0000, speedCmd = 16'h0000;
	pulse_fmt_t fmtSel = FMT_QUADRATURE;
	logic pinA, pinB, wbAck, positionControl, servoActive, stopStart;
	logic movingAvgFilter, overspeedEnable;
	logic [3:0] commandSource;
	logic [15:0] stopDistance, loopGain;
	int miscompares = 0, checksDone = 0, cycles = 0;

	always #10 clock = ~clock;

	position_command_pulse_decoder dut (.clock(clock), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(datI), .wb_dat_o(wbDat), .wb_ack_o(wbAck),
		.commandPulseInputA(pinA), .commandPulseInputB(pinB),
		.servoEnable(servoEnable), .runForward(runForward),
		.runReverse(runReverse), .photoSwitch(photoSwitch),
		.closedLoopVectorMode(vecMode), .spindleOrient(spindleOrient),
		.orientMoving(orientMoving), .torqueCommand(torqueCmd),
		.speedCommand(speedCmd), .positionCount(positionCount),
		.positionControl(positionControl), .servoActive(servoActive),
		.commandSource(commandSource), .stopStart(stopStart),
		.stopDistance(stopDistance), .loopGain(loopGain),
		.movingAvgFilter(movingAvgFilter),
		.overspeedEnable(overspeedEnable));

	pulse_source partner (.clock(clock), .rst_n(rst_n), .go(go), .up(up),
		.skip(skip), .fmt(fmtSel), .pinA(pinA), .pinB(pinB));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic endOfTest;
		if (miscompares == 0 && checksDone > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// The bench timeout bounds the wait for ack
	task automatic wbCycle(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		@(posedge clock);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		datI <= d;
		sel <= 4'hF;
		@(posedge clock);
		while (wbAck !== 1'h1) @(posedge clock);
		rdat = wbDat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		wbCycle(1'h1, a, d);
	endtask

	task automatic rdCheck(input logic [7:0] a, input logic [31:0] exp);
		wbCycle(1'h0, a, 32'h0000_0000);
		check(rdat, exp);
	endtask

	task automatic step(input logic u);
		@(posedge clock);
		go <= 1'h1;
		up <= u;
		@(posedge clock);
		go <= 1'h0;
		repeat (12) @(posedge clock);
	endtask

	// Double quadrature step; the pulse formats see no pulse at all
	task automatic skipStep;
		@(posedge clock);
		go <= 1'h1;
		skip <= 1'h1;
		@(posedge clock);
		go <= 1'h0;
		skip <= 1'h0;
		repeat (12) @(posedge clock);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic resetValues;
		check(loopGain, G1);
		rdCheck(8'h00, 32'h0000_0000);
		rdCheck(8'h08, G1);
		rdCheck(8'h0C, G2);
		rdCheck(8'h10, 32'h0000_0000);
		rdCheck(8'h1C, 32'h0000_0005);
		wr(8'h2C, 32'h0000_FFFF);
		rdCheck(8'h2C, 32'h0000_0000);
	endtask

	task automatic controlMode;
		wr(8'h00, 32'h0000_0001);
		repeat (3) @(posedge clock);
		check(positionControl, 1'h0);
		vecMode <= 1'h1;
		repeat (3) @(posedge clock);
		check(positionControl, 1'h1);
		wr(8'h00, 32'h0000_0000);
		repeat (3) @(posedge clock);
		check(positionControl, 1'h0);
		for (int s = 0; s < 3; s++) begin
			wr(8'h00, (s << 4) | 1);
			check(commandSource, s);
		end
	endtask

	task automatic servoTest;
		wr(8'h00, 32'h0000_0001);
		for (int i = 0; i < 8; i++) begin
			{servoEnable, runForward, runReverse} <= i[2:0];
			repeat (6) @(posedge clock);
			check(servoActive, i != 0);
		end
		wr(8'h00, 32'h0000_0011);
		{servoEnable, runForward, runReverse} <= 3'h4;
		repeat (6) @(posedge clock);
		check(servoActive, 1'h0);
		spindleOrient <= 1'h1;
		repeat (3) @(posedge clock);
		check(servoActive, 1'h1);
		spindleOrient <= 1'h0;
		servoEnable <= 1'h0;
	endtask

	// Direction codes: 0 fwd, 1 reverse, 2 follow reverse run (high), 3 follow reverse run (low)
	task automatic formats;
		logic [31:0] base;
		logic [31:0] want;
		wr(8'h00, 32'h0000_0001);
		for (int d = 0; d < 4; d++) begin
			for (int f = 0; f < 4; f++) begin
				runReverse <= (d == 2);
				fmtSel <= pulse_fmt_t'(f);
				wr(8'h04, f | (d << 4));
				repeat (10) @(posedge clock);
				base = positionCount;
				// Pulse-only carries no sign: the down step counts too
				want = (f == 2) ? 32'h0000_0004 : 32'h0000_0002;
				if (d == 1 || d == 2) begin
					want = -want;
				end
				step(1'h1);
				step(1'h1);
				step(1'h1);
				step(1'h0);
				check(positionCount - base, want);
				skipStep;
				check(positionCount - base, want);
			end
		end
		runReverse <= 1'h0;
	endtask

	task automatic photoStop;
		logic [31:0] n;
		wr(8'h20, 32'h0000_1234);
		check(stopDistance, 16'h1234);
		for (int s = 0; s < 3; s += 2) begin
			wr(8'h00, (s << 4) | 1);
			n = 32'h0000_0000;
			photoSwitch <= 1'h1;
			repeat (10) begin
				@(posedge clock);
				n = n + stopStart;
			end
			photoSwitch <= 1'h0;
			repeat (4) @(posedge clock);
			check(n, s == 2);
		end
	endtask

	task automatic filterBits;
		for (int b = 0; b < 4; b++) begin
			wr(8'h04, b << 12);
			check({overspeedEnable, movingAvgFilter}, b);
		end
	endtask

	task automatic gains;
		wr(8'h1C, 32'h0000_0000);
		wr(8'h14, 32'h0000_0064);
		wr(8'h18, 32'h0000_0064);
		for (int m = 0; m < 6; m++) begin
			wr(8'h10, m);
			torqueCmd <= 16'h0064;
			speedCmd <= 16'h0063;
			repeat (4) @(posedge clock);
			check(loopGain, m == 1 ? G2 : G1);
			torqueCmd <= 16'h0063;
			speedCmd <= 16'h0064;
			repeat (4) @(posedge clock);
			check(loopGain, m == 2 ? G2 : G1);
		end
		wr(8'h10, 32'h0000_0001);
		torqueCmd <= 16'h0064;
		spindleOrient <= 1'h1;
		repeat (4) @(posedge clock);
		check(loopGain, G1);
		orientMoving <= 1'h1;
		repeat (4) @(posedge clock);
		check(loopGain, G2);
		spindleOrient <= 1'h0;
		orientMoving <= 1'h0;
		wr(8'h10, 32'h0000_0000);
		wr(8'h1C, 32'h0000_0001);
		wr(8'h10, 32'h0000_0001);
		// One or two ticks of halving land strictly between the gains
		repeat (60) @(posedge clock);
		check(loopGain > G1 && loopGain < G2, 1'h1);
		repeat (3000) @(posedge clock);
		check(loopGain, G2);
	endtask

	// ------------------------------------------------------------
	// Sequence and timeout
	// ------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			endOfTest;
		end
	end

	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'h1;
		resetValues;
		controlMode;
		servoTest;
		formats;
		photoStop;
		filterBits;
		gains;
		endOfTest;
	end
endmodule
